// >>> bench/cbsc_client_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Client side: transaction attributes and event pulses
// ------------------------------------------------------------
module cbsc_client_model (
	input  wire logic          pclk,  // Clock
	output cbsc_pkg::cbsc_txn_t txn,  // Attributes presented
	output logic               fault, // Context fault pulse
	output logic               aflag, // Access flag fault pulse
	output logic               maint  // Maintenance pulse
);
	initial begin
		txn = '0;
		fault = 1'b0;
		aflag = 1'b0;
		maint = 1'b0;
	end

	// One-cycle event pulse, bit0 fault, bit1 aflag, bit2 maint
	task automatic pulse(input logic [2:0] ev);
		@(posedge pclk);
		fault <= ev[0];
		aflag <= ev[1];
		maint <= ev[2];
		@(posedge pclk);
		{maint, aflag, fault} <= 3'h0;
	endtask

	// New attributes after an edge
	task automatic present(input cbsc_pkg::cbsc_txn_t t);
		@(posedge pclk);
		txn <= t;
	endtask
endmodule

`default_nettype wire

// >>> bench/cbsc_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module cbsc_top_tb_top;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, seed, r;
	cbsc_pkg::cbsc_txn_t   txn_in, txn_out, et;
	cbsc_pkg::cbsc_fault_t fault_act;
	logic                  fault_in, aflag_in, maint_in, xl_en, big_endian;
	logic                  maint_bcast, fault_hold, irq;
	logic [32:0]           rq[$];
	int                    fail_count = 0;
	int                    total_checks = 0;

	cbsc_top i_cbsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .txn_in(txn_in), .fault_in(fault_in), .aflag_in(aflag_in),
		.maint_in(maint_in), .txn_out(txn_out), .xl_en(xl_en), .big_endian(big_endian),
		.maint_bcast(maint_bcast), .fault_act(fault_act), .fault_hold(fault_hold), .irq(irq));
	cbsc_client_model i_cbsc_client_model (.pclk(pclk), .txn(txn_in), .fault(fault_in),
		.aflag(aflag_in), .maint(maint_in));

	// Clock and random source
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// APB transfer; a read notes {pslverr, prdata} expected
	task automatic apb(input logic wr, input logic [11:0] a, input logic [32:0] d);
		if (!wr)
			rq.push_back(d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d[31:0]};
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i <= 20; i++) begin
			@(posedge pclk);
			if (pready)
				break;
			if (i == 20) begin
				fail_count++;
				wrap_up();
			end
		end
		{psel, penable} <= 2'b00;
	endtask

	// Read monitor takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (rq.size() == 0)
				check(33'h0, 33'h1);
			else
				check({pslverr, prdata}, rq.pop_front());
		end
	end

	function automatic cbsc_pkg::cbsc_txn_t exp_txn(input logic [31:0] c,
		input cbsc_pkg::cbsc_txn_t t);
		logic [1:0] sm[4];
		sm = '{2'h0, cbsc_pkg::SH_OUTER, cbsc_pkg::SH_INNER, cbsc_pkg::SH_NONE};
		exp_txn = t;
		if (!c[0]) begin
			exp_txn.attr = c[19:16];
			if (c[23:22] != 2'h0)
				exp_txn.share = sm[c[23:22]];
		end
		if (t.barrier && c[15:14] > exp_txn.share)
			exp_txn.share = c[15:14];
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		seed = 32'h58a77b18;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, cbsc_pkg::CTRL_OFFSET, 33'h6);
		apb(0, cbsc_pkg::STATUS_OFFSET, 33'h0);
		apb(1, cbsc_pkg::CTRL_OFFSET, 33'hffffffff);
		apb(0, cbsc_pkg::CTRL_OFFSET, 33'h00efc1ff);
		apb(0, 12'h010, 33'h100000000);
		apb(1, 12'h010, 33'h0);
		apb(0, cbsc_pkg::CTRL_OFFSET, 33'h00efc1ff);
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			r = seed;
			apb(1, cbsc_pkg::CTRL_OFFSET, {1'b0, r});
			apb(0, cbsc_pkg::CTRL_OFFSET, {1'b0, r & cbsc_pkg::CTRL_WMASK | 32'h6});
			seed = xs(seed);
			et = seed[6:0];
			i_cbsc_client_model.present(et);
			@(posedge pclk);
			#1;
			check(txn_out, exp_txn(r, et));
			check({xl_en, big_endian}, {r[0], r[4]});
		end
		apb(1, cbsc_pkg::IRQEN_OFFSET, 33'h3);
		for (int i = 0; i < 8; i++) begin
			r = {23'h0, i[1], i[0], i[2] ^ i[0], i[2], 5'h0};
			apb(1, cbsc_pkg::CTRL_OFFSET, {1'b0, r});
			i_cbsc_client_model.pulse(3'h1);
			#1;
			check(fault_act, {~r[7], r[7], r[5], ~r[8]});
			@(posedge pclk);
			#1;
			check({irq, fault_hold}, {r[6], ~r[8]});
			apb(0, cbsc_pkg::STATUS_OFFSET, 33'h1);
			apb(1, cbsc_pkg::CLEAR_OFFSET, 33'h3);
			@(posedge pclk);
			#1;
			check({irq, fault_hold}, 2'b00);
		end
		// Fault and clear land on one edge: set wins
		fork
			apb(1, cbsc_pkg::CLEAR_OFFSET, 33'h1);
			begin
				@(posedge pclk);
				i_cbsc_client_model.pulse(3'h1);
			end
		join
		apb(0, cbsc_pkg::STATUS_OFFSET, 33'h1);
		apb(1, cbsc_pkg::CLEAR_OFFSET, 33'h3);
		for (int i = 0; i < 2; i++) begin
			apb(1, cbsc_pkg::CTRL_OFFSET, {11'h0, i[0], 17'h0, ~i[0], 3'h0});
			i_cbsc_client_model.pulse(3'h6);
			#1;
			check(maint_bcast, i[0]);
			apb(0, cbsc_pkg::STATUS_OFFSET, {31'h0, i[0], i[0]});
			apb(1, cbsc_pkg::CLEAR_OFFSET, 33'h3);
		end
		repeat (3) @(posedge pclk);
		check(rq.size(), 0);
		wrap_up();
	end
endmodule

`default_nettype wire

// >>> design/cbsc_attr.sv
`timescale 1ns/100ps
`default_nettype none

// Attribute path of a transaction through the bank
module cbsc_attr (
	input  wire logic             xl_en,     // Translation enable
	input  wire logic [1:0]       share_ov,  // Shareability override
	input  wire logic [3:0]       attr_ov,   // Memory attribute overlay
	input  wire logic [1:0]       bar_min,   // Barrier upgrade
	input  wire cbsc_pkg::cbsc_txn_t t_in,   // Incoming attributes
	output cbsc_pkg::cbsc_txn_t   t_out      // Outgoing attributes
);

	wire logic [1:0] share_sel;
	wire logic [1:0] bar_share;
	wire logic [1:0] base_share;

	// Override codes: 1 outer, 2 inner, 3 non-shareable
	assign share_sel = (share_ov == 2'h1) ? cbsc_pkg::SH_OUTER :
	                   (share_ov == 2'h2) ? cbsc_pkg::SH_INNER : cbsc_pkg::SH_NONE;
	// override decode, only while translation off
	assign base_share = (!xl_en && share_ov != 2'h0) ? share_sel : t_in.share;
	assign bar_share = (t_in.barrier && bar_min > base_share) ? bar_min : base_share;
	assign t_out.share = bar_share;
	// attribute overlay, encoding passed as is
	assign t_out.attr = xl_en ? t_in.attr : attr_ov;
	assign t_out.barrier = t_in.barrier;

endmodule

`default_nettype wire

// >>> design/cbsc_pkg.sv
package cbsc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] CLEAR_OFFSET  = 12'h008;
	localparam logic [11:0] IRQEN_OFFSET  = 12'h00c;

	// Writable bits of the control register
	localparam logic [31:0] CTRL_WMASK = 32'h00ef_c1fb;
	// Reset value: access flag and remap enables high
	localparam logic [31:0] CTRL_RESET = 32'h0000_0006;

	// Field positions
	localparam int SHARE_LSB = 22;
	localparam int BCAST_BIT = 21;
	localparam int ATTR_LSB  = 16;
	localparam int BARUP_LSB = 14;
	localparam int HUF_BIT   = 8;
	localparam int FRS_BIT   = 7;
	localparam int FIE_BIT   = 6;
	localparam int FRE_BIT   = 5;
	localparam int END_BIT   = 4;
	localparam int AFDIS_BIT = 3;
	localparam int XLEN_BIT  = 0;

	// Status event bits
	localparam int EV_FAULT = 0;
	localparam int EV_AFLAG = 1;
	localparam int EV_W     = 2;

	// Shareability encodings
	localparam logic [1:0] SH_NONE  = 2'h0;
	localparam logic [1:0] SH_INNER = 2'h1;
	localparam logic [1:0] SH_OUTER = 2'h2;
	localparam logic [1:0] SH_SYS   = 2'h3;

	// Transaction attributes passing through the bank
	typedef struct packed {
		logic [1:0] share;
		logic [3:0] attr;
		logic       barrier;
	} cbsc_txn_t;

	// Fault handling decision
	typedef struct packed {
		logic terminate;
		logic stall;
		logic abort;
		logic block_next;
	} cbsc_fault_t;

endpackage

// >>> design/cbsc_sticky.sv
`timescale 1ns/100ps
`default_nettype none

// Sticky event bit: set wins over clear
module cbsc_sticky (
	input  wire logic pclk,    // Clock
	input  wire logic presetn, // Async reset, low
	input  wire logic set,     // Event pulse
	input  wire logic clr,     // Software clear pulse
	output logic      q        // Sticky flag
);

	// Hold flag until cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> design/cbsc_top.sv
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module cbsc_top (
	input  wire logic              pclk,        // Clock, 125 MHz
	input  wire logic              presetn,     // Async reset, low
	input  wire logic              psel,        // APB select
	input  wire logic              penable,     // APB enable
	input  wire logic              pwrite,      // APB direction
	input  wire logic [11:0]       paddr,       // APB byte address
	input  wire logic [31:0]       pwdata,      // APB write data
	output logic      [31:0]       prdata,      // APB read data
	output logic                   pready,      // APB ready
	output logic                   pslverr,     // APB error
	input  wire cbsc_pkg::cbsc_txn_t txn_in,    // Incoming transaction attributes
	input  wire logic              fault_in,    // Context fault pulse
	input  wire logic              aflag_in,    // Access flag fault pulse
	input  wire logic              maint_in,    // Invalidate-all maintenance pulse
	output cbsc_pkg::cbsc_txn_t    txn_out,     // Outgoing attributes, registered
	output logic                   xl_en,       // Translation enable
	output logic                   big_endian,  // Table entries big endian
	output logic                   maint_bcast, // Broadcast maintenance pulse
	output cbsc_pkg::cbsc_fault_t  fault_act,   // Fault action, registered
	output logic                   fault_hold,  // Later transactions held
	output logic                   irq          // Interrupt level
);

	// ------------------------------------------------------------
	// Registers and bus decode
	// ------------------------------------------------------------
	logic [31:0]          ctrl_reg;
	logic [cbsc_pkg::EV_W-1:0] irqen_reg;
	wire logic [cbsc_pkg::EV_W-1:0] status;
	logic                 hold_reg;
	cbsc_pkg::cbsc_txn_t  attr_q;

	wire logic acc      = psel && penable && pready;
	wire logic wr       = acc && pwrite;
	wire logic hit_ctrl = (paddr == cbsc_pkg::CTRL_OFFSET);
	wire logic hit_stat = (paddr == cbsc_pkg::STATUS_OFFSET);
	wire logic hit_clr  = (paddr == cbsc_pkg::CLEAR_OFFSET);
	wire logic hit_ien  = (paddr == cbsc_pkg::IRQEN_OFFSET);
	wire logic mapped   = hit_ctrl | hit_stat | hit_clr | hit_ien;

	// Named control fields
	wire logic xlat_on  = ctrl_reg[cbsc_pkg::XLEN_BIT];
	wire logic huf      = ctrl_reg[cbsc_pkg::HUF_BIT];
	wire logic frs      = ctrl_reg[cbsc_pkg::FRS_BIT];
	wire logic fie      = ctrl_reg[cbsc_pkg::FIE_BIT];
	wire logic fre      = ctrl_reg[cbsc_pkg::FRE_BIT];
	wire logic af_dis   = ctrl_reg[cbsc_pkg::AFDIS_BIT];
	wire logic bc_force = ctrl_reg[cbsc_pkg::BCAST_BIT];

	// Read mux; reserved bits masked off
	wire logic [31:0] rd_mux =
		hit_ctrl ? (ctrl_reg & cbsc_pkg::CTRL_WMASK) | cbsc_pkg::CTRL_RESET :
		hit_stat ? {30'h0, status} :
		hit_ien  ? {30'h0, irqen_reg} : 32'h0;

	// Control register write; reset values
	// writes to reserved bits dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= cbsc_pkg::CTRL_RESET;
		end else if (wr && hit_ctrl) begin
			ctrl_reg <= (pwdata & cbsc_pkg::CTRL_WMASK) | cbsc_pkg::CTRL_RESET;
		end
	end

	// Interrupt enable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irqen_reg <= '0;
		end else if (wr && hit_ien) begin
			irqen_reg <= pwdata[cbsc_pkg::EV_W-1:0];
		end
	end

	// Zero-wait APB answer, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// ------------------------------------------------------------
	// Fault events and interrupt
	// ------------------------------------------------------------
	wire logic clr_wr = wr && hit_clr;
	// access flag fault suppressed when disabled
	wire logic aflag_rep = aflag_in && !af_dis;
	wire logic fault_ev  = fault_in || aflag_rep;
	wire logic [cbsc_pkg::EV_W-1:0] ev_set = {aflag_rep, fault_ev};

	genvar gi;
	generate
		for (gi = 0; gi < cbsc_pkg::EV_W; gi++) begin : g_st
			cbsc_sticky u_st (
				.pclk    (pclk),
				.presetn (presetn),
				.set     (ev_set[gi]),
				.clr     (clr_wr && pwdata[gi]),
				.q       (status[gi])
			);
		end
	endgenerate

	// interrupt only with fault enable set
	wire logic irq_next = |(status & irqen_reg) && fie;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_next;
		end
	end

	// terminate or stall, abort on report enable
	cbsc_pkg::cbsc_fault_t fa_next;
	assign fa_next.terminate  = fault_ev && !frs;
	assign fa_next.stall      = fault_ev && frs;
	assign fa_next.abort      = fault_ev && fre;
	assign fa_next.block_next = fault_ev && !huf;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_act <= '0;
		end else begin
			fault_act <= fa_next;
		end
	end

	// hold later transactions until fault status cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_reg <= 1'b0;
		end else if (fault_ev && !huf) begin
			hold_reg <= 1'b1;
		end else if (clr_wr && pwdata[cbsc_pkg::EV_FAULT]) begin
			hold_reg <= 1'b0;
		end
	end
	assign fault_hold = hold_reg;

	// ------------------------------------------------------------
	// Transaction attributes and status outputs
	// ------------------------------------------------------------
	cbsc_pkg::cbsc_txn_t attr_c;
	cbsc_attr u_attr (
		.xl_en    (xlat_on),
		.share_ov (ctrl_reg[cbsc_pkg::SHARE_LSB +: 2]),
		.attr_ov  (ctrl_reg[cbsc_pkg::ATTR_LSB +: 4]),
		.bar_min  (ctrl_reg[cbsc_pkg::BARUP_LSB +: 2]),
		.t_in     (txn_in),
		.t_out    (attr_c)
	);

	// Register the attribute path and mode outputs
	// enable and endianness exported
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			attr_q      <= '0;
			xl_en       <= 1'b0;
			big_endian  <= 1'b0;
			maint_bcast <= 1'b0;
		end else begin
			attr_q      <= attr_c;
			xl_en       <= xlat_on;
			big_endian  <= ctrl_reg[cbsc_pkg::END_BIT];
			maint_bcast <= maint_in && bc_force;
		end
	end
	assign txn_out = attr_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Helpers for the bus checks
	wire logic        ctrl_rd_setup = psel && !penable && !pwrite && hit_ctrl;
	wire logic        apb_setup     = psel && !penable;
	wire logic [31:0] fixed_mask    = ~(cbsc_pkg::CTRL_WMASK | cbsc_pkg::CTRL_RESET);

	a_share_override: assert property (
		!xlat_on && ctrl_reg[23:22] == 2'h3 && !txn_in.barrier |=> txn_out.share == cbsc_pkg::SH_NONE)
		else $error("share override not applied");
	a_share_bypass: assert property (
		xlat_on && !txn_in.barrier |=> txn_out.share == $past(txn_in.share))
		else $error("share changed while translating");
	a_attr_overlay: assert property (
		!xlat_on |=> txn_out.attr == $past(ctrl_reg[19:16]))
		else $error("attribute overlay missing");
	a_attr_xl: assert property (
		xlat_on |=> txn_out.attr == $past(txn_in.attr))
		else $error("attribute changed while translating");
	a_fault_term: assert property (
		fault_in && !frs |=> fault_act.terminate && !fault_act.stall)
		else $error("terminate not chosen");
	a_fault_abort: assert property (
		fault_in |=> fault_act.abort == $past(fre))
		else $error("abort mismatch");
	a_irq_gate: assert property (
		!fie |=> !irq)
		else $error("irq without enable");
	a_hold_set: assert property (
		fault_in && !huf |=> fault_hold)
		else $error("hold not set");
	a_afault_sup: assert property (
		af_dis && aflag_in && !fault_in && !status[0] && !(clr_wr) |=> !status[0])
		else $error("suppressed fault reported");
	a_aflag_rep: assert property (
		aflag_in && !af_dis |=> status[cbsc_pkg::EV_AFLAG])
		else $error("access flag fault not reported");
	a_bcast_gate: assert property (
		maint_in && !bc_force |=> !maint_bcast)
		else $error("broadcast without force");
	a_bcast_on: assert property (
		maint_in && bc_force |=> maint_bcast)
		else $error("forced broadcast missing");
	a_ctrl_fixed: assert property (
		ctrl_reg[2:1] == 2'h3 && (ctrl_reg & fixed_mask) == 32'h0)
		else $error("fixed bits changed");
	a_ready_pulse: assert property (
		apb_setup |=> pready)
		else $error("ready missing after setup");
	a_ready_once: assert property (
		pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_unmapped: assert property (
		apb_setup && !mapped |=> pslverr)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (
		apb_setup && mapped |=> !pslverr)
		else $error("error on mapped address");
	a_ctrl_write: assert property (
		wr && hit_ctrl |=>
		ctrl_reg == (($past(pwdata) & cbsc_pkg::CTRL_WMASK) | cbsc_pkg::CTRL_RESET))
		else $error("control write not applied");
	a_ctrl_keep: assert property (
		!(wr && hit_ctrl) |=> $stable(ctrl_reg))
		else $error("control changed without write");
	a_unmapped_wr: assert property (
		wr && !mapped |=> $stable(ctrl_reg) && $stable(irqen_reg))
		else $error("unmapped write changed state");
	a_rd_reserved: assert property (
		ctrl_rd_setup |=> (prdata & fixed_mask) == 32'h0)
		else $error("reserved bits read nonzero");
	a_rd_ones: assert property (
		ctrl_rd_setup |=> prdata[2:1] == 2'h3)
		else $error("enable bits not read as one");
	a_xl_on: assert property (
		xlat_on |=> xl_en)
		else $error("translation enable not exported");
	a_xl_off: assert property (
		!xlat_on |=> !xl_en)
		else $error("translation enable stuck");
	a_big_end: assert property (
		ctrl_reg[cbsc_pkg::END_BIT] |=> big_endian)
		else $error("big endian not exported");
	a_little_end: assert property (
		!ctrl_reg[cbsc_pkg::END_BIT] |=> !big_endian)
		else $error("little endian not exported");
	a_fault_stall: assert property (
		fault_ev && frs |=> fault_act.stall && !fault_act.terminate)
		else $error("stall not chosen");
	a_abort_off: assert property (
		!fault_ev |=> !fault_act.abort)
		else $error("abort without fault");
	a_status_set: assert property (
		fault_ev |=> status[cbsc_pkg::EV_FAULT])
		else $error("fault status not set");
	a_irq_raise: assert property (
		fie && |(status & irqen_reg) |=> irq)
		else $error("enabled interrupt missing");
	a_hold_clear: assert property (
		clr_wr && pwdata[cbsc_pkg::EV_FAULT] && !fault_ev |=> !fault_hold)
		else $error("hold not released");
	a_huf_pass: assert property (
		huf && !fault_hold |=> !fault_hold)
		else $error("hold set under hit-under-fault");

	c_fault_irq: cover property (fault_in && fie ##2 irq);
	c_stall:     cover property (fault_in && frs ##1 fault_act.stall);
	c_ctrl_wr:   cover property (wr && hit_ctrl);
	c_barrier:   cover property (txn_in.barrier && ctrl_reg[15:14] == 2'h3);
	c_hold_clr:  cover property (fault_hold ##1 !fault_hold);

endmodule

`default_nettype wire
